/* File: inc/hsc_pkg.sv */
package hsc_pkg;
    // ==========================================================
    // register map (byte addresses)
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] STATUS_OFS    = 8'h04;
    localparam logic [7:0] CTS_ON_OFS    = 8'h08;
    localparam logic [7:0] CTS_OFF_OFS   = 8'h0c;
    localparam logic [7:0] TXDATA_OFS    = 8'h10;
    localparam logic [7:0] RXDATA_OFS    = 8'h14;
    localparam logic [7:0] BAUD_OFS      = 8'h18;
    // ==========================================================
    // ctrl field positions
    localparam int CTRL_RTS_EN_BIT  = 0;
    localparam int CTRL_SERVER_BIT  = 1;
    localparam int CTRL_SYNC_BIT    = 2;
    localparam int CTRL_SLEEP_LSB   = 4;
    // status field positions
    localparam int ST_CMD_BIT       = 0;
    localparam int ST_CTS_BIT       = 1;
    localparam int ST_FORCED_BIT    = 2;
    localparam int ST_RXVLD_BIT     = 3;
    localparam int ST_TXRDY_BIT     = 4;
    localparam int ST_AWAKE_BIT     = 5;
    localparam int ST_LEVEL_LSB     = 8;
    localparam int ST_RXCMD_BIT     = 16;
    // ==========================================================
    // reset values
    localparam logic [31:0] CTRL_RST    = 32'h0000_0000;
    localparam logic [3:0]  CTS_ON_RST  = 4'h6;
    localparam logic [3:0]  CTS_OFF_RST = 4'h2;
    // ==========================================================
    // timing
    localparam int CLK_HZ          = 200_000_000;
    localparam int FORCED_BAUD     = 9600;
    localparam logic [15:0] FORCED_DIV = 16'(CLK_HZ / (FORCED_BAUD * 16));
    localparam logic [15:0] DIV_RST    = FORCED_DIV;
    localparam int OVS             = 16;
    typedef enum logic [1:0] {
        HSC_AWAKE_T, HSC_SLEEP1_T, HSC_SLEEP2_T, HSC_SLEEP3_T
    } hsc_sleep_t;
endpackage : hsc_pkg

/* File: rtl/hsc_fifo.sv */
module hsc_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_chk
        $error("depth must be a power of two");
    end
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0]      wp_r, wp_nxt, rp_r, rp_nxt;
    logic             push, pop;
    always_comb begin
        push   = in_valid && in_ready;
        pop    = out_valid && out_ready;
        wp_nxt = push ? wp_r + 1'b1 : wp_r;
        rp_nxt = pop ? rp_r + 1'b1 : rp_r;
    end
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_r <= '0;
            rp_r <= '0;
        end else begin
            wp_r <= wp_nxt;
            rp_r <= rp_nxt;
        end
    end
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_r[AW-1:0]] <= in_data;
        end
    end
    assign level     = wp_r - rp_r;
    assign in_ready  = level != (AW+1)'(DEPTH);
    assign out_valid = level != '0;
    assign out_data  = mem[rp_r[AW-1:0]];
endmodule : hsc_fifo

/* File: rtl/hsc_top.sv */
// Implementation choices: the placing of the registers and register access over AHB-Lite.
module hsc_top #(
    parameter int FIFO_DEPTH = 8
) (
    input  wire logic        CLK_SYS,
    input  wire logic        RESET_N,
    input  wire logic [31:0] HADDR,
    input  wire logic [1:0]  HTRANS,
    input  wire logic        HWRITE,
    input  wire logic [2:0]  HSIZE,
    input  wire logic [31:0] HWDATA,
    input  wire logic        HSEL,
    input  wire logic        HREADY,
    output logic [31:0]      HRDATA,
    output logic             HREADYOUT,
    output logic             HRESP,
    input  wire logic        RXD,
    output logic             TXD,
    input  wire logic        FORCE_WAKE_N,
    input  wire logic        CMD_SEL_N,
    input  wire logic        RTS_N,
    output logic             CTS,
    output logic             IN_RANGE_N
);
    localparam int LW = $clog2(FIFO_DEPTH) + 1;
    if (FIFO_DEPTH < 4) begin : g_depth_chk
        $error("fifo too shallow for thresholds");
    end
    // ==========================================================
    // pin synchronisers: three flops, change taken when 2nd and 3rd agree
    logic [3:0] s1_r, s2_r, s3_r, pin_r, pin_nxt;
    logic [3:0] pin_raw;
    assign pin_raw = {RXD, FORCE_WAKE_N, CMD_SEL_N, RTS_N};
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pin_nxt[i] = (s2_r[i] == s3_r[i]) ? s3_r[i] : pin_r[i];
        end
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            s1_r  <= 4'hf;
            s2_r  <= 4'hf;
            s3_r  <= 4'hf;
            pin_r <= 4'hf;
        end else begin
            s1_r  <= pin_raw;
            s2_r  <= s1_r;
            s3_r  <= s2_r;
            pin_r <= pin_nxt;
        end
    end
    logic rxd_s, wake_n_s, cmd_n_s, rts_n_s;
    assign {rxd_s, wake_n_s, cmd_n_s, rts_n_s} = pin_r;
    // ==========================================================
    // strap capture after reset release; settles once the pipeline is full
    logic [2:0] strap_cnt_r, strap_cnt_nxt;
    logic       forced_r, forced_nxt;
    always_comb begin
        strap_cnt_nxt = strap_cnt_r;
        forced_nxt    = forced_r;
        // pin_r first shows the pin after the 4th edge, so sample on the 5th
        if (strap_cnt_r != 3'h5) begin
            strap_cnt_nxt = strap_cnt_r + 3'h1;
            if (strap_cnt_r == 3'h4) begin
                forced_nxt = !wake_n_s;
            end
        end
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            strap_cnt_r <= 3'h0;
            forced_r    <= 1'b0;
        end else begin
            strap_cnt_r <= strap_cnt_nxt;
            forced_r    <= forced_nxt;
        end
    end
    // ==========================================================
    // ahb-lite slave registers
    logic [31:0] ctrl_r, ctrl_nxt;
    logic [3:0]  cts_on_r, cts_on_nxt, cts_off_r, cts_off_nxt;
    logic [15:0] div_r, div_nxt;
    logic        wr_pend_r, wr_pend_nxt, rd_pend_r, rd_pend_nxt;
    logic [7:0]  addr_r, addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        tx_push, rx_pop;
    logic        txf_in_ready, rxf_out_valid, txf_out_valid;
    logic [8:0]  rxf_out;
    logic [7:0]  txf_out;
    logic [LW-1:0] rx_level;
    logic        cts_r, tx_busy;
    hsc_pkg::hsc_sleep_t sleep_r, sleep_nxt;
    logic        addr_ph;
    assign addr_ph = HSEL && HREADY && HTRANS[1];
    always_comb begin
        ctrl_nxt    = ctrl_r;
        cts_on_nxt  = cts_on_r;
        cts_off_nxt = cts_off_r;
        div_nxt     = div_r;
        wr_pend_nxt = addr_ph && HWRITE;
        rd_pend_nxt = addr_ph && !HWRITE;
        addr_nxt    = addr_ph ? HADDR[7:0] : addr_r;
        rdata_nxt   = 32'h0;
        tx_push     = 1'b0;
        rx_pop      = 1'b0;
        if (wr_pend_r) begin
            case (addr_r)
                hsc_pkg::CTRL_OFS: ctrl_nxt = HWDATA;
                hsc_pkg::CTS_ON_OFS: begin
                    if (HWDATA[3:0] > cts_off_r) cts_on_nxt = HWDATA[3:0];
                end
                hsc_pkg::CTS_OFF_OFS: begin
                    if (HWDATA[3:0] < cts_on_r) cts_off_nxt = HWDATA[3:0];
                end
                hsc_pkg::TXDATA_OFS: tx_push = txf_in_ready;
                hsc_pkg::BAUD_OFS: begin
                    if (HWDATA[15:0] != 16'h0) div_nxt = HWDATA[15:0];
                end
                default: ;
            endcase
        end
        if (rd_pend_nxt) begin
            case (HADDR[7:0])
                hsc_pkg::CTRL_OFS:    rdata_nxt = ctrl_r;
                hsc_pkg::CTS_ON_OFS:  rdata_nxt = {28'h0, cts_on_r};
                hsc_pkg::CTS_OFF_OFS: rdata_nxt = {28'h0, cts_off_r};
                hsc_pkg::BAUD_OFS:    rdata_nxt = {16'h0, forced_r ? hsc_pkg::FORCED_DIV : div_r};
                hsc_pkg::STATUS_OFS: begin
                    rdata_nxt[hsc_pkg::ST_CMD_BIT]    = !cmd_n_s;
                    rdata_nxt[hsc_pkg::ST_CTS_BIT]    = cts_r;
                    rdata_nxt[hsc_pkg::ST_FORCED_BIT] = forced_r;
                    rdata_nxt[hsc_pkg::ST_RXVLD_BIT]  = rxf_out_valid;
                    rdata_nxt[hsc_pkg::ST_TXRDY_BIT]  = txf_in_ready;
                    rdata_nxt[hsc_pkg::ST_AWAKE_BIT]  = sleep_r == hsc_pkg::HSC_AWAKE_T;
                    rdata_nxt[hsc_pkg::ST_LEVEL_LSB +: LW] = rx_level;
                end
                hsc_pkg::RXDATA_OFS: begin
                    rdata_nxt = {15'h0, rxf_out_valid & rxf_out[8], 8'h0, rxf_out[7:0]};
                    rdata_nxt[hsc_pkg::ST_RXCMD_BIT] = rxf_out_valid & rxf_out[8];
                    rx_pop = rxf_out_valid;
                end
                default: rdata_nxt = 32'h0;
            endcase
        end
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            ctrl_r    <= hsc_pkg::CTRL_RST;
            cts_on_r  <= hsc_pkg::CTS_ON_RST;
            cts_off_r <= hsc_pkg::CTS_OFF_RST;
            div_r     <= hsc_pkg::DIV_RST;
            wr_pend_r <= 1'b0;
            rd_pend_r <= 1'b0;
            addr_r    <= 8'h0;
            rdata_r   <= 32'h0;
        end else begin
            ctrl_r    <= ctrl_nxt;
            cts_on_r  <= cts_on_nxt;
            cts_off_r <= cts_off_nxt;
            div_r     <= div_nxt;
            wr_pend_r <= wr_pend_nxt;
            rd_pend_r <= rd_pend_nxt;
            addr_r    <= addr_nxt;
            rdata_r   <= rdata_nxt;
        end
    end
    assign HRDATA    = rdata_r;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;
    rdata_idle_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !rd_pend_r |-> HRDATA == 32'h0) else $error("read data outside data phase");
    // ==========================================================
    // sleep: software enters a mode, a low wake pin always leaves it
    always_comb begin
        sleep_nxt = sleep_r;
        if (!wake_n_s) begin
            sleep_nxt = hsc_pkg::HSC_AWAKE_T;
        end else if (ctrl_nxt != ctrl_r) begin
            sleep_nxt = hsc_pkg::hsc_sleep_t'(ctrl_nxt[hsc_pkg::CTRL_SLEEP_LSB +: 2]);
        end
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) sleep_r <= hsc_pkg::HSC_AWAKE_T;
        else          sleep_r <= sleep_nxt;
    end
    // ==========================================================
    // baud tick: 16x oversample, forced strap overrides the programmed divider
    logic [15:0] bdiv_r, bdiv_nxt, div_use;
    logic        tick;
    assign div_use = forced_r ? hsc_pkg::FORCED_DIV : div_r;
    always_comb begin
        tick     = bdiv_r >= div_use - 16'h1;
        bdiv_nxt = tick ? 16'h0 : bdiv_r + 16'h1;
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) bdiv_r <= 16'h0;
        else          bdiv_r <= bdiv_nxt;
    end
    // ==========================================================
    // serial receiver (8-N-1) and transmitter, 16x ticks
    logic [3:0] rx_os_r, rx_os_nxt, tx_os_r, tx_os_nxt;
    logic [3:0] rx_bit_r, rx_bit_nxt, tx_bit_r, tx_bit_nxt;
    logic [7:0] rx_sh_r, rx_sh_nxt;
    logic [9:0] tx_sh_r, tx_sh_nxt;
    logic       rx_act_r, rx_act_nxt, tx_act_r, tx_act_nxt;
    logic       rx_push, rxf_in_ready, tx_pop;
    logic       awake;
    assign awake = sleep_r == hsc_pkg::HSC_AWAKE_T;
    always_comb begin
        rx_os_nxt = rx_os_r; rx_bit_nxt = rx_bit_r; rx_sh_nxt = rx_sh_r;
        rx_act_nxt = rx_act_r; rx_push = 1'b0;
        if (tick) begin
            if (!rx_act_r) begin
                if (!rxd_s) begin
                    rx_act_nxt = 1'b1; rx_os_nxt = 4'h0; rx_bit_nxt = 4'h0;
                end
            end else begin
                rx_os_nxt = rx_os_r + 4'h1;
                if (rx_os_r == 4'h7) begin
                    if (rx_bit_r == 4'h0 && rxd_s) rx_act_nxt = 1'b0;
                    else if (rx_bit_r >= 4'h1 && rx_bit_r <= 4'h8)
                        rx_sh_nxt = {rxd_s, rx_sh_r[7:1]};
                    else if (rx_bit_r == 4'h9) begin
                        rx_act_nxt = 1'b0;
                        rx_push    = rxd_s;
                    end
                end
                if (rx_os_r == 4'hf) rx_bit_nxt = rx_bit_r + 4'h1;
            end
        end
        tx_os_nxt = tx_os_r; tx_bit_nxt = tx_bit_r; tx_sh_nxt = tx_sh_r;
        tx_act_nxt = tx_act_r; tx_pop = 1'b0;
        if (!tx_act_r) begin
            if (txf_out_valid && awake && (!ctrl_r[hsc_pkg::CTRL_RTS_EN_BIT] || !rts_n_s)) begin
                tx_pop = 1'b1; tx_act_nxt = 1'b1; tx_os_nxt = 4'h0; tx_bit_nxt = 4'h0;
                tx_sh_nxt = {1'b1, txf_out, 1'b0};
            end
        end else if (tick) begin
            tx_os_nxt = tx_os_r + 4'h1;
            if (tx_os_r == 4'hf) begin
                tx_sh_nxt  = {1'b1, tx_sh_r[9:1]};
                tx_bit_nxt = tx_bit_r + 4'h1;
                if (tx_bit_r == 4'h9) tx_act_nxt = 1'b0;
            end
        end
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) begin
            rx_os_r <= 4'h0; rx_bit_r <= 4'h0; rx_sh_r <= 8'h0; rx_act_r <= 1'b0;
            tx_os_r <= 4'h0; tx_bit_r <= 4'h0; tx_sh_r <= 10'h3ff; tx_act_r <= 1'b0;
        end else begin
            rx_os_r <= rx_os_nxt; rx_bit_r <= rx_bit_nxt;
            rx_sh_r <= rx_sh_nxt; rx_act_r <= rx_act_nxt;
            tx_os_r <= tx_os_nxt; tx_bit_r <= tx_bit_nxt;
            tx_sh_r <= tx_sh_nxt; tx_act_r <= tx_act_nxt;
        end
    end
    assign TXD     = tx_act_r ? tx_sh_r[0] : 1'b1;
    assign tx_busy = tx_act_r;
    // bit 8 tags command (1) or payload (0) at the moment the stop bit lands
    hsc_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_rxf (
        .clk      (CLK_SYS),
        .rst_n    (RESET_N),
        .in_data  ({!cmd_n_s, rx_sh_r}),
        .in_valid (rx_push),
        .in_ready (rxf_in_ready),
        .out_data (rxf_out),
        .out_valid(rxf_out_valid),
        .out_ready(rx_pop),
        .level    (rx_level)
    );
    hsc_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_txf (
        .clk      (CLK_SYS),
        .rst_n    (RESET_N),
        .in_data  (HWDATA[7:0]),
        .in_valid (tx_push),
        .in_ready (txf_in_ready),
        .out_data (txf_out),
        .out_valid(txf_out_valid),
        .out_ready(tx_pop),
        .level    ()
    );
    // ==========================================================
    // cts hysteresis; a full fifo drops bytes, which is why the host must pause
    logic cts_nxt;
    always_comb begin
        cts_nxt = cts_r;
        if (!cts_r && rx_level >= LW'(cts_on_r)) cts_nxt = 1'b1;
        else if (cts_r && rx_level < LW'(cts_off_r)) cts_nxt = 1'b0;
    end
    always_ff @(posedge CLK_SYS or negedge RESET_N) begin
        if (!RESET_N) cts_r <= 1'b0;
        else          cts_r <= cts_nxt;
    end
    assign CTS = cts_r;
    assign IN_RANGE_N = ctrl_r[hsc_pkg::CTRL_SERVER_BIT] ? 1'b0
                      : !ctrl_r[hsc_pkg::CTRL_SYNC_BIT];
    // ==========================================================
    cts_rise_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        (!cts_r && rx_level >= LW'(cts_on_r)) |=> cts_r) else $error("cts did not rise");
    cts_hold_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        (cts_r && rx_level >= LW'(cts_off_r)) |=> cts_r) else $error("cts fell early");
    cts_fall_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        (cts_r && rx_level < LW'(cts_off_r)) |=> !cts_r) else $error("cts stuck");
    thr_order_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        cts_on_r > cts_off_r) else $error("thresholds out of order");
    server_range_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        ctrl_r[hsc_pkg::CTRL_SERVER_BIT] |-> !IN_RANGE_N) else $error("server not in range");
    client_range_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !ctrl_r[hsc_pkg::CTRL_SERVER_BIT] |-> IN_RANGE_N == !ctrl_r[hsc_pkg::CTRL_SYNC_BIT])
        else $error("client range wrong");
    wake_exit_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        !wake_n_s |=> awake) else $error("wake ignored");
    rts_gate_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        (tx_pop && ctrl_r[hsc_pkg::CTRL_RTS_EN_BIT]) |-> !rts_n_s) else $error("sent without rts");
    force_baud_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        forced_r |=> bdiv_r < hsc_pkg::FORCED_DIV) else $error("forced rate lost");
    cmd_tag_a: assert property (@(posedge CLK_SYS) disable iff (!RESET_N)
        (rx_push && rxf_in_ready) |-> u_rxf.in_data[8] == !cmd_n_s) else $error("bad tag");
endmodule : hsc_top

/* File: tb/hsc_host_model.sv */
module hsc_host_model #(
    parameter int BIT = 32
) (
    input  wire logic clk,
    input  wire logic dev_txd,
    input  wire logic cts,
    output logic      host_txd
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] rx_q[$];
    logic [7:0] sh;
    int         stuck = 0;
    initial host_txd = 1'b1;
    // ==========================================================
    // receive side: sample each bit at its middle
    always begin
        @(posedge clk);
        if (dev_txd === 1'b0) begin
            repeat (BIT / 2) @(posedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (BIT) @(posedge clk);
                sh[i] = dev_txd;
            end
            repeat (BIT) @(posedge clk);
            if (dev_txd === 1'b1) rx_q.push_back(sh);
        end
    end
    // ==========================================================
    // send side: line idles high, as the pull-up would leave it
    task automatic send(input logic [7:0] b);
        logic [9:0] f;
        int         n;
        f = {1'b1, b, 1'b0};
        n = 0;
        @(posedge clk);
        // holding off while cts is high keeps the device buffer from overflowing
        while (cts === 1'b1 && n < 50000) begin
            @(posedge clk);
            n++;
        end
        if (n >= 50000) stuck++;
        for (int i = 0; i < 10; i++) begin
            host_txd <= f[i];
            repeat (BIT) @(posedge clk);
        end
    endtask : send
endmodule : hsc_host_model

/* File: tb/tb_host_serial_control_pins.sv */
module tb_host_serial_control_pins;
    timeunit 1ns;
    timeprecision 1ps;
    // small divider so a frame costs hundreds of cycles, not hundreds of thousands
    localparam int DIV   = 2;
    localparam int BIT   = hsc_pkg::OVS * DIV;
    localparam int FRAME = 10 * BIT;
    logic        clk_sys      = 1'b0;
    logic        reset_n      = 1'b0;
    logic [31:0] haddr        = 32'h0;
    logic [1:0]  htrans       = 2'h0;
    logic        hwrite       = 1'b0;
    logic [31:0] hwdata       = 32'h0;
    logic        hsel         = 1'b0;
    logic        force_wake_n = 1'b1;
    logic        cmd_sel_n    = 1'b1;
    logic        rts_n        = 1'b1;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic        hreadyout;
    logic        hresp;
    logic        rxd;
    logic        txd;
    logic        cts;
    logic        in_range_n;
    int          error_cnt    = 0;
    int          comparisons  = 0;

    always #2.5 clk_sys = ~clk_sys;

    hsc_top #(.FIFO_DEPTH(8)) u_dut (
        .CLK_SYS(clk_sys), .RESET_N(reset_n), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HSEL(hsel),
        .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
        .RXD(rxd), .TXD(txd), .FORCE_WAKE_N(force_wake_n), .CMD_SEL_N(cmd_sel_n),
        .RTS_N(rts_n), .CTS(cts), .IN_RANGE_N(in_range_n)
    );
    hsc_host_model #(.BIT(BIT)) u_host (
        .clk(clk_sys), .dev_txd(txd), .cts(cts), .host_txd(rxd)
    );
    // ==========================================================
    // checking and ending
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic end_sim();
        $display("comparisons %0d errors %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_sim
    initial begin
        repeat (60000) @(posedge clk_sys);
        error_cnt++;
        end_sim();
    end
    // ==========================================================
    // bus and pin tasks
    task automatic wait_rdy();
        int n;
        n = 0;
        do begin
            @(posedge clk_sys);
            n++;
        end while (hreadyout !== 1'b1 && n < 64);
        if (hreadyout !== 1'b1) begin
            error_cnt++;
            end_sim();
        end
    endtask : wait_rdy
    task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        htrans <= 2'b10;
        hwrite <= wr;
        haddr <= {24'h0, a};
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
        chk("hresp", 32'(hresp), 32'h0);
    endtask : ahb
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        ahb(1'b1, a, d);
    endtask : wr
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        ahb(1'b0, a, 32'h0);
        chk(nm, rd, exp);
    endtask : rdchk
    task automatic rst(input logic strap_n);
        reset_n <= 1'b0;
        force_wake_n <= strap_n;
        repeat (6) @(posedge clk_sys);
        reset_n <= 1'b1;
        repeat (6) @(posedge clk_sys);
        force_wake_n <= 1'b1;
    endtask : rst
    // ==========================================================
    // main sequence
    initial begin
        rst(1'b0);
        ahb(1'b0, hsc_pkg::STATUS_OFS, 32'h0);
        chk("forced", 32'(rd[hsc_pkg::ST_FORCED_BIT]), 32'h1);
        rst(1'b1);
        ahb(1'b0, hsc_pkg::STATUS_OFS, 32'h0);
        chk("forced", 32'(rd[hsc_pkg::ST_FORCED_BIT]), 32'h0);
        rdchk("ctrl", hsc_pkg::CTRL_OFS, hsc_pkg::CTRL_RST);
        rdchk("cts_on", hsc_pkg::CTS_ON_OFS, 32'(hsc_pkg::CTS_ON_RST));
        rdchk("cts_off", hsc_pkg::CTS_OFF_OFS, 32'(hsc_pkg::CTS_OFF_RST));
        rdchk("baud", hsc_pkg::BAUD_OFS, 32'(hsc_pkg::DIV_RST));
        wr(8'h1c, 32'hffff_ffff);
        rdchk("unmapped", 8'h1c, 32'h0);
        // thresholds must keep upper above lower
        wr(hsc_pkg::CTS_OFF_OFS, 32'h6);
        rdchk("cts_off", hsc_pkg::CTS_OFF_OFS, 32'h2);
        wr(hsc_pkg::CTS_ON_OFS, 32'h2);
        rdchk("cts_on", hsc_pkg::CTS_ON_OFS, 32'h6);
        wr(hsc_pkg::CTS_ON_OFS, 32'h5);
        rdchk("cts_on", hsc_pkg::CTS_ON_OFS, 32'h5);
        wr(hsc_pkg::CTS_ON_OFS, 32'h6);
        for (int i = 0; i < 4; i++) begin
            wr(hsc_pkg::CTRL_OFS, 32'(i) << 1);
            repeat (2) @(posedge clk_sys);
            chk("in_range_n", 32'(in_range_n), 32'(i == 0));
        end
        wr(hsc_pkg::CTRL_OFS, 32'h0);
        wr(hsc_pkg::BAUD_OFS, 32'(DIV));
        // receive path, alternating command and payload bytes
        for (int k = 0; k < 6; k++) begin
            cmd_sel_n <= k[0];
            u_host.send(8'h30 + 8'(k));
            repeat (4) @(posedge clk_sys);
            chk("cts_rise", 32'(cts), 32'(k == 5));
        end
        chk("host_stall", 32'(u_host.stuck), 32'h0);
        ahb(1'b0, hsc_pkg::STATUS_OFS, 32'h0);
        chk("rx_level", 32'(rd[hsc_pkg::ST_LEVEL_LSB +: 4]), 32'h6);
        for (int k = 0; k < 6; k++) begin
            rdchk("rxdata", hsc_pkg::RXDATA_OFS, {15'h0, ~k[0], 8'h0, 8'h30 + 8'(k)});
            repeat (3) @(posedge clk_sys);
            chk("cts_fall", 32'(cts), 32'(k <= 3));
        end
        // transmit path held off by rts: fill the buffer until it refuses
        wr(hsc_pkg::CTRL_OFS, 32'h1);
        for (int k = 0; k < 9; k++) wr(hsc_pkg::TXDATA_OFS, 32'h0c0 + 32'(k));
        ahb(1'b0, hsc_pkg::STATUS_OFS, 32'h0);
        chk("tx_room", 32'(rd[hsc_pkg::ST_TXRDY_BIT]), 32'h0);
        repeat (3 * FRAME) @(posedge clk_sys);
        chk("rts_hold", 32'(u_host.rx_q.size()), 32'h0);
        rts_n <= 1'b0;
        repeat (9 * FRAME) @(posedge clk_sys);
        chk("tx_count", 32'(u_host.rx_q.size()), 32'h8);
        for (int k = 0; k < 8; k++) chk("tx_byte", 32'(u_host.rx_q[k]), 32'h0c0 + 32'(k));
        // every sleep mode is left by a low wake pin
        for (int m = 1; m < 4; m++) begin
            wr(hsc_pkg::CTRL_OFS, 32'(m) << 4);
            ahb(1'b0, hsc_pkg::STATUS_OFS, 32'h0);
            chk("asleep", 32'(rd[hsc_pkg::ST_AWAKE_BIT]), 32'h0);
            if (m == 1) begin
                wr(hsc_pkg::TXDATA_OFS, 32'h5a);
                repeat (2 * FRAME) @(posedge clk_sys);
                chk("sleep_tx", 32'(u_host.rx_q.size()), 32'h8);
            end
            force_wake_n <= 1'b0;
            repeat (2) @(posedge clk_sys);
            force_wake_n <= 1'b1;
            repeat (8) @(posedge clk_sys);
            ahb(1'b0, hsc_pkg::STATUS_OFS, 32'h0);
            chk("awake", 32'(rd[hsc_pkg::ST_AWAKE_BIT]), 32'h1);
            if (m == 1) begin
                repeat (FRAME + 2 * BIT) @(posedge clk_sys);
                chk("wake_tx", 32'(u_host.rx_q.size()), 32'h9);
                chk("wake_byte", 32'(u_host.rx_q[8]), 32'h5a);
            end
        end
        // external reset pulse in mid-run
        wr(hsc_pkg::CTRL_OFS, 32'h6);
        rst(1'b1);
        chk("cts_rst", 32'(cts), 32'h0);
        chk("txd_rst", 32'(txd), 32'h1);
        chk("range_rst", 32'(in_range_n), 32'h1);
        rdchk("ctrl", hsc_pkg::CTRL_OFS, hsc_pkg::CTRL_RST);
        rdchk("baud", hsc_pkg::BAUD_OFS, 32'(hsc_pkg::DIV_RST));
        end_sim();
    end
endmodule : tb_host_serial_control_pins
